// File: hdl/bitbus_pkg.sv
package bitbus_pkg;
   localparam logic [7:0] ctrl_offset = 8'hd8;
   localparam logic [7:0] data_offset = 8'hd9;
   localparam logic [7:0] cfg_offset = 8'hc8;
   localparam logic [7:0] ctrl_reset = 8'h81;
   localparam logic [7:0] cfg_reset = 8'h00;
   localparam int b_rbit = 7;
   localparam int b_atn = 6;
   localparam int b_rdy = 5;
   localparam int b_arl = 4;
   localparam int b_str = 3;
   localparam int b_stp = 2;
   localparam int b_own = 1;
   localparam int b_cxa = 7;
   localparam int b_idle = 6;
   localparam int b_cdr = 5;
   localparam int b_clear_arbitration_lost = 4;
   localparam int b_clear_start_seen = 3;
   localparam int b_clear_stop_seen = 2;
   localparam int b_send_repeated_start = 1;
   localparam int b_send_stop = 0;
   localparam int b_target_enable = 7;
   localparam int b_ownership_request = 6;
   localparam int b_gie = 1;
   localparam int b_bie = 0;
   localparam int setup_ns = 4700;
   localparam int clk_ns = 25;
   localparam int setup_cyc = (setup_ns + clk_ns - 1) / clk_ns;
endpackage : bitbus_pkg

// File: hdl/bitbus_ctrl.sv
`timescale 1ns/1ps
module bitbus_ctrl (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [7:0] writedata_i,
   output logic [7:0] readdata_o,
   output logic waitrequest_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic bus_timeout_i,
   output logic irq_o,
   output logic xmit_active_o
);
   import bitbus_pkg::*;

   typedef enum {st_none, st_rstart, st_stop} cmd_t;

   // ==========================================
   // Pin synchronisers
   logic [1:0] scl_s_q, sda_s_q;
   logic scl_p_q, sda_p_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         scl_p_q <= scl_s_q[1];
         sda_p_q <= sda_s_q[1];
      end
   end
   logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
   assign scl = scl_s_q[1];
   assign sda = sda_s_q[1];
   assign scl_rise = scl & ~scl_p_q;
   assign scl_fall = ~scl & scl_p_q;
   assign start_det = scl & scl_p_q & sda_p_q & ~sda;
   assign stop_det = scl & scl_p_q & ~sda_p_q & sda;

   // ==========================================
   // Bus access decode
   logic wr_ctrl, wr_data, rd_data, wr_cfg;
   logic [7:0] wd;
   assign waitrequest_o = 1'b0;
   assign wd = writedata_i;
   assign wr_ctrl = write_i && address_i == ctrl_offset;
   assign wr_data = write_i && address_i == data_offset;
   assign wr_cfg = write_i && address_i == cfg_offset;
   assign rd_data = read_i && address_i == data_offset;

   // ==========================================
   // Configuration
   logic target_enable_q, ownership_request_q, gie_q, bie_q, enabled;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         target_enable_q <= cfg_reset[b_target_enable];
         ownership_request_q <= cfg_reset[b_ownership_request];
         gie_q <= cfg_reset[b_gie];
         bie_q <= cfg_reset[b_bie];
      end else if (bus_timeout_i) begin
         target_enable_q <= 1'b0;
         ownership_request_q <= 1'b0;
      end else if (wr_cfg) begin
         target_enable_q <= wd[b_target_enable];
         ownership_request_q <= wd[b_ownership_request];
         gie_q <= wd[b_gie];
         bie_q <= wd[b_bie];
      end
   end
   assign enabled = target_enable_q | ownership_request_q;

   // ==========================================
   // Bus state: busy, idle slave, owner
   logic busy_q, idle_q, own_q, stop_pend_q;
   logic act_rise, act_start, act_stop;
   assign act_rise = enabled && scl_rise && (own_q || !idle_q);
   assign act_start = enabled && start_det && (own_q || !idle_q);
   assign act_stop = enabled && stop_det && (own_q || !idle_q);

   logic arl_set, arl_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_q <= 1'b0;
         idle_q <= 1'b1;
         own_q <= ctrl_reset[b_own];
         stop_pend_q <= 1'b0;
      end else begin
         if (bus_timeout_i || stop_det) busy_q <= 1'b0;
         else if (start_det) busy_q <= 1'b1;
         if (!enabled || (wr_ctrl && wd[b_idle] && !own_q)) idle_q <= 1'b1;
         else if (start_det) idle_q <= 1'b0;
         if (wr_ctrl && wd[b_send_stop] && !ownership_request_q) stop_pend_q <= 1'b1;
         else if (!own_q) stop_pend_q <= 1'b0;
         if (arl_set || !enabled || (stop_pend_q && stop_det)) own_q <= 1'b0;
         else if (ownership_request_q && !busy_q && !own_q) own_q <= 1'b1;
      end
   end

   // ==========================================
   // Transmit path
   logic xa_q, xbit_q, sda_drv_q;
   cmd_t cmd_q;
   logic [12:0] hold_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         xa_q <= 1'b0;
         xbit_q <= 1'b1;
         cmd_q <= st_none;
      end else begin
         if (arl_q || arl_set) xa_q <= 1'b0;
         else if (wr_data || (wr_ctrl && (wd[b_send_repeated_start] || wd[b_send_stop]))) xa_q <= 1'b1;
         else if (rd_data || (wr_ctrl && wd[b_cxa])) xa_q <= 1'b0;
         if (wr_data) xbit_q <= wd[b_rbit];
         else if (wr_ctrl && wd[b_send_repeated_start]) xbit_q <= 1'b1;
         else if (wr_ctrl && wd[b_send_stop]) xbit_q <= 1'b0;
         if (wr_ctrl && wd[b_send_repeated_start]) cmd_q <= st_rstart;
         else if (wr_ctrl && wd[b_send_stop]) cmd_q <= st_stop;
         else if (wr_data || scl_fall || stop_det || arl_set) cmd_q <= st_none;
      end
   end
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) hold_q <= '0;
      else if (!scl) hold_q <= '0;
      else if (hold_q != 13'(setup_cyc)) hold_q <= hold_q + 13'h1;
   end
   logic hold_done;
   assign hold_done = hold_q == 13'(setup_cyc);
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) sda_drv_q <= 1'b0;
      else if (!xa_q || !enabled) sda_drv_q <= 1'b0;
      else if (!scl) sda_drv_q <= ~xbit_q;
      else if (hold_done && cmd_q == st_rstart) sda_drv_q <= 1'b1;
      else if (hold_done && cmd_q == st_stop) sda_drv_q <= 1'b0;
   end
   // Release history: the synchronised SDA lags our own drive by two clocks
   logic [1:0] drv_hist_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) drv_hist_q <= 2'h0;
      else drv_hist_q <= {drv_hist_q[0], sda_drv_q};
   end
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_drv_q;
   assign xmit_active_o = xa_q;

   // ==========================================
   // Arbitration loss causes
   logic sent_one, cmd_rs, cmd_sp;
   assign sent_one = xa_q && !sda_drv_q;
   assign cmd_rs = cmd_q == st_rstart;
   assign cmd_sp = cmd_q == st_stop;
   always_comb begin
      arl_set = 1'b0;
      if (xa_q && enabled) begin
         if (scl_rise && sent_one && !sda && !cmd_sp) arl_set = 1'b1;
         if (start_det && sent_one && !cmd_rs) arl_set = 1'b1;
         if (own_q && cmd_rs && scl_fall && !sda_drv_q) arl_set = 1'b1;
         if (own_q && cmd_sp && scl && hold_done && !sda && !sda_drv_q && drv_hist_q == 2'h0)
            arl_set = 1'b1;
      end
   end

   // ==========================================
   // Flags: set wins over clear
   logic rbit_q, rdy_q, str_q, stp_q, attention_flag;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rbit_q <= ctrl_reset[b_rbit];
         rdy_q <= 1'b0;
         arl_q <= 1'b0;
         str_q <= 1'b0;
         stp_q <= 1'b0;
      end else begin
         if (scl_rise) rbit_q <= sda;
         if (act_rise) rdy_q <= 1'b1;
         else if (rd_data || wr_data || (wr_ctrl && wd[b_cdr])) rdy_q <= 1'b0;
         if (arl_set) arl_q <= 1'b1;
         else if (wr_ctrl && wd[b_clear_arbitration_lost]) arl_q <= 1'b0;
         if (act_start) str_q <= 1'b1;
         else if (wr_ctrl && wd[b_clear_start_seen]) str_q <= 1'b0;
         if (act_stop) stp_q <= 1'b1;
         else if (wr_ctrl && wd[b_clear_stop_seen]) stp_q <= 1'b0;
      end
   end
   assign attention_flag = rdy_q | arl_q | str_q | stp_q;

   // ==========================================
   // Clock stretch
   logic scl_hold_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) scl_hold_q <= 1'b0;
      else if (!enabled) scl_hold_q <= 1'b0;
      else if (!scl && attention_flag) scl_hold_q <= 1'b1;
      else if (!attention_flag) scl_hold_q <= 1'b0;
   end
   assign scl_o = 1'b0;
   assign scl_oe_o = scl_hold_q;

   // ==========================================
   // Interrupt and read data
   logic irq_q;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= gie_q && bie_q && attention_flag;
      end
   end
   assign irq_o = irq_q;

   always_comb begin
      readdata_o = 8'h00;
      if (address_i == ctrl_offset) begin
         readdata_o[b_rbit] = rbit_q;
         readdata_o[b_atn] = attention_flag;
         readdata_o[b_rdy] = rdy_q;
         readdata_o[b_arl] = arl_q;
         readdata_o[b_str] = str_q;
         readdata_o[b_stp] = stp_q;
         readdata_o[b_own] = own_q;
         readdata_o[0] = 1'b1;
      end else if (address_i == data_offset) begin
         readdata_o[b_rbit] = rbit_q;
      end else if (address_i == cfg_offset) begin
         readdata_o = {target_enable_q, ownership_request_q, 4'h0, gie_q, bie_q};
      end
   end
endmodule : bitbus_ctrl

// File: tb/bitbus_props.sv
`timescale 1ns/1ps
module bitbus_props
   import bitbus_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [7:0] writedata_i,
   input wire logic [7:0] readdata_o,
   input wire logic scl_oe_o,
   input wire logic sda_oe_o,
   input wire logic irq_o,
   input wire logic xmit_active_o
);
   // ========
   // Checks
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic rc, wc, clr_q;
   assign rc = read_i && address_i == ctrl_offset;
   assign wc = write_i && address_i == ctrl_offset;
   // Last write cleared all three flags
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i) clr_q <= 1'b0;
      else if (write_i) clr_q <= wc && writedata_i[4:2] == 3'h7;
      else if (read_i) clr_q <= 1'b0;
   a_atn_is_or: assert property (rc |-> readdata_o[6] == |readdata_o[5:2])
      else $error("attention not OR of flags");
   a_irq_quiet: assert property (rc && !readdata_o[6] |=> !irq_o)
      else $error("irq without attention");
   a_data_zeros: assert property (read_i && address_i == data_offset |-> !readdata_o[6:0])
      else $error("data low bits not zero");
   a_cxa_clears: assert property (wc && writedata_i[7] && !writedata_i[1:0] |=> !xmit_active_o)
      else $error("transmit stays active");
   a_sda_needs_xa: assert property (sda_oe_o |-> xmit_active_o || $past(xmit_active_o))
      else $error("sda driven while not transmitting");
   a_arl_kills_xa: assert property (rc && readdata_o[4] |-> !xmit_active_o)
      else $error("transmit active with loss");
   a_hold_scl: assert property (rc && readdata_o[6] && scl_oe_o |=> scl_oe_o)
      else $error("scl released with flags");
   a_flags_clear: assert property (clr_q && rc |-> readdata_o[4:2] == 3'h0)
      else $error("flags not cleared");
   a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !sda_oe_o && !scl_oe_o)
      else $error("outputs active after reset");
   cover property (rc && readdata_o[5]);
   cover property (rc && readdata_o[4]);
   cover property (rc && readdata_o[2]);
endmodule : bitbus_props
bind bitbus_ctrl bitbus_props u_bitbus_props (.*);

// File: tb/bus_peer.sv
`timescale 1ns/1ps
module bus_peer (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_oe_o,
   output logic sda_oe_o
);
   // ========
   // Far bus party, 200 ns bit clock
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   // Release SCL, honour stretching
   task automatic rise;
      int n;
      n = 0;
      #100 scl_oe_o = 1'b0;
      while (!scl_i && n < 500) begin
         #25 n++;
      end
      #100;
   endtask : rise
   task automatic start_cond;
      sda_oe_o = 1'b1;
      #100 scl_oe_o = 1'b1;
   endtask : start_cond
   task automatic send_bit(input logic b);
      sda_oe_o = !b;
      rise();
      scl_oe_o = 1'b1;
   endtask : send_bit
   task automatic stop_cond;
      sda_oe_o = 1'b1;
      rise();
      sda_oe_o = 1'b0;
   endtask : stop_cond
endmodule : bus_peer

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
   import bitbus_pkg::*;
   logic mclk_i, rst_i, read_i, write_i, bus_timeout_i, p_scl, p_sda;
   logic [7:0] address_i, writedata_i, readdata_o;
   logic waitrequest_o, scl_oe_o, sda_oe_o, irq_o, xmit_active_o;
   wire scl = !(scl_oe_o || p_scl);
   wire sda = !(sda_oe_o || p_sda);
   int mismatches, checks;
   bitbus_ctrl u_bitbus_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda),
      .sda_o(), .sda_oe_o(sda_oe_o), .bus_timeout_i(bus_timeout_i), .irq_o(irq_o),
      .xmit_active_o(xmit_active_o));
   bus_peer u_bus_peer (.scl_i(scl), .sda_i(sda), .scl_oe_o(p_scl), .sda_oe_o(p_sda));
   // ========
   // Tasks
   task automatic check(input string what, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge mclk_i);
      address_i <= a;
      writedata_i <= d;
      read_i <= !w;
      write_i <= w;
      do @(posedge mclk_i); while (waitrequest_o !== 1'b0 && ++n < 64);
      if (n >= 64) mismatches++;
      q = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, exp, m);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check("read", q & m, exp);
   endtask : rd
   task automatic wt(input int c);
      repeat (c) @(posedge mclk_i);
   endtask : wt
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = !mclk_i;
   end
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
   // ========
   // Sequence
   initial begin
      {rst_i, read_i, write_i, bus_timeout_i, address_i, writedata_i} = {1'b1, 19'h0};
      wt(2);
      rst_i <= 1'b0;
      rd(ctrl_offset, 8'h81, 8'hff);
      rd(8'h00, 8'h00, 8'hff);
      wr(cfg_offset, 8'h83);
      wr(ctrl_offset, 8'h40);
      u_bus_peer.start_cond();
      u_bus_peer.send_bit(1'b1);
      wt(8);
      rd(ctrl_offset, 8'he0, 8'hfe);
      check("irq", 8'(irq_o), 8'h01);
      check("hold", 8'(scl_oe_o), 8'h01);
      rd(data_offset, 8'h80, 8'hff);
      rd(ctrl_offset, 8'h80, 8'hfe);
      u_bus_peer.send_bit(1'b0);
      wt(8);
      rd(ctrl_offset, 8'h60, 8'hfe);
      wr(ctrl_offset, 8'h20);
      rd(ctrl_offset, 8'h00, 8'hfe);
      u_bus_peer.stop_cond();
      wt(8);
      rd(ctrl_offset, 8'h64, 8'hfe);
      wr(ctrl_offset, 8'h00);
      rd(ctrl_offset, 8'h64, 8'hfe);
      wr(ctrl_offset, 8'h3c);
      rd(ctrl_offset, 8'h00, 8'hfe);
      u_bus_peer.start_cond();
      wt(8);
      rd(ctrl_offset, 8'h48, 8'hfe);
      wr(ctrl_offset, 8'h08);
      wr(data_offset, 8'h80);
      wt(1);
      check("xa", 8'(xmit_active_o), 8'h01);
      u_bus_peer.send_bit(1'b0);
      wt(8);
      rd(ctrl_offset, 8'h70, 8'hfe);
      check("xa", 8'(xmit_active_o), 8'h00);
      wr(ctrl_offset, 8'h20);
      wt(4);
      check("hold", 8'(scl_oe_o), 8'h01);
      wr(ctrl_offset, 8'h10);
      wt(4);
      check("hold", 8'(scl_oe_o), 8'h00);
      u_bus_peer.stop_cond();
      wr(cfg_offset, 8'h40);
      wt(10);
      rd(ctrl_offset, 8'h02, 8'h02);
      wr(data_offset, 8'h00);
      wt(4);
      check("sda", 8'(sda_oe_o), 8'h00);
      wr(ctrl_offset, 8'h80);
      wt(1);
      check("xa", 8'(xmit_active_o), 8'h00);
      report_and_stop();
   end
endmodule : tb
